// >>> shared/ebc_arb_cfg.svh
// Purpose: Constants for the external bus hold arbitration block
// Assumes: Included by bare name
// Notes: Widths, idle levels and reset values
`ifndef EBC_ARB_CFG_SVH
`define EBC_ARB_CFG_SVH
`define EBC_DATA_W 16
`define EBC_SEG_W 8
`define EBC_NUM_CS 5
`define EBC_NUM_BUSCON 5
`define EBC_ALE_IDLE 1'b0
`define EBC_STROBE_IDLE 1'b1
`define EBC_ACK_RST 1'b1
`define EBC_SYNC_RST 1'b1
`endif

// >>> shared/ebc_arb_pkg.sv
// Purpose: Types for the external bus hold arbitration block
// Assumes: Nothing
// Notes: State machine states only
package ebc_arb_pkg;
    typedef enum logic [1:0] {
        ARB_NORMAL,
        ARB_DRAIN,
        ARB_HOLD,
        ARB_RESUME
    } arb_state_e;
endpackage : ebc_arb_pkg

// >>> src/bus_hold_arbiter.sv
// Purpose: Hold/acknowledge arbitration and idle pin control of the external bus
// Assumes: Cycle inputs come from the bus cycle engine on core_clk
// Notes: All pin outputs are registered; one cycle behind their causes
//
// Overview of operation
// [R1] Idle interface floats muxed port, keeps last address and segment driven.
// [R2] Idle: address latch strobe low, read/write high, matching chip select driven.
// [R3] Other master asks for the bus by pulling hold request low.
// [R4] After sync, finish running cycle, float bus, then drive acknowledge low; code floats bus and drives acknowledge low on the same edge.
// [R5] In hold float address/data; strobe pulled low, commands pulled high weakly.
// [R6] In hold push-pull chip selects go high, open-drain ones float.
// [R7] Internal work continues in hold; stall only on external access need.
// [R8] Bus request output asserted only in hold, when external access needed.
// [R9] Hold requests ignored while arbitration enable bit is clear.
// [R10] Arbitration pins keep their function once enable has been set.
// [R11] On hold release: sync, acknowledge high, then drive strobes again.
// [R12] Arbiter may answer bus request; regain always starts by releasing hold.
// [R13] Other master may release hold any time without a bus request.
// [R14] Interface counts as enabled when any bus-active bit is set.
// [R15] Hold request passes a two-flop synchroniser before the state machine.
`timescale 1ns/10ps
`include "ebc_arb_cfg.svh"
module bus_hold_arbiter
    import ebc_arb_pkg::*;
#(
    parameter int DATA_W = `EBC_DATA_W,
    parameter int SEG_W = `EBC_SEG_W,
    parameter int NUM_CS = `EBC_NUM_CS,
    parameter int NUM_BUSCON = `EBC_NUM_BUSCON
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic hold_req_n,
    input wire logic arbitration_enable,
    input wire logic [NUM_BUSCON-1:0] bus_active_bit,
    input wire logic ext_access_req,
    input wire logic cyc_active,
    input wire logic cyc_ale,
    input wire logic cyc_rd_n,
    input wire logic cyc_write_low_byte_n,
    input wire logic cyc_byte_high_enable_n,
    input wire logic [DATA_W-1:0] cyc_ad_out,
    input wire logic cyc_ad_oe,
    input wire logic [DATA_W-1:0] cyc_addr,
    input wire logic [SEG_W-1:0] cyc_seg,
    input wire logic [NUM_CS-1:0] cyc_cs_n,
    input wire logic cs_enable,
    input wire logic [NUM_CS-1:0] cs_open_drain,
    input wire logic addr_port_used,
    output logic [DATA_W-1:0] muxed_addr_data_out,
    output logic muxed_addr_data_oe,
    output logic [DATA_W-1:0] intra_segment_addr_out,
    output logic intra_segment_addr_oe,
    output logic [SEG_W-1:0] seg_addr_out,
    output logic seg_addr_oe,
    output logic ale_out,
    output logic ale_oe,
    output logic ale_pulldown_en,
    output logic rd_n_out,
    output logic write_low_byte_n,
    output logic byte_high_enable_n,
    output logic cmd_oe,
    output logic cmd_pullup_en,
    output logic [NUM_CS-1:0] cs_n_out,
    output logic [NUM_CS-1:0] cs_oe,
    output logic bus_grant_ack_n,
    output logic bus_want_back_n,
    output logic arb_pins_oe,
    output logic cycle_allow,
    output logic core_stall
);

    // ****************************************
    // Hold request synchroniser
    // ****************************************
    logic hold_meta_q, hold_sync_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hold_meta_q <= `EBC_SYNC_RST;
            hold_sync_q <= `EBC_SYNC_RST;
        end else if (clk_en) begin
            hold_meta_q <= hold_req_n; // R15
            hold_sync_q <= hold_meta_q; // R15
        end
    end

    // ****************************************
    // Arbitration state machine
    // ****************************************
    arb_state_e state_q, state_d;
    logic bus_if_en, float_d;

    assign bus_if_en = |bus_active_bit; // R14

    always_comb begin
        state_d = state_q;
        case (state_q)
            ARB_NORMAL: begin
                if (arbitration_enable && !hold_sync_q) begin // R9
                    state_d = ARB_DRAIN;
                end
            end
            ARB_DRAIN: begin
                if (hold_sync_q) begin // R13
                    state_d = ARB_NORMAL;
                end else if (!cyc_active) begin // R4
                    state_d = ARB_HOLD;
                end
            end
            ARB_HOLD: begin
                if (hold_sync_q) begin // R11
                    state_d = ARB_RESUME;
                end
            end
            ARB_RESUME: state_d = ARB_NORMAL; // R11
            default: state_d = ARB_NORMAL;
        endcase
    end

    assign float_d = (state_d == ARB_HOLD) || (state_d == ARB_RESUME);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= ARB_NORMAL;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // Arbitration pins and core handshake
    // ****************************************
    logic ack_n_q, want_n_q, pull_q, armed_q, allow_q, stall_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_n_q <= `EBC_ACK_RST;
            want_n_q <= `EBC_ACK_RST;
            pull_q <= 1'b0;
            armed_q <= 1'b0;
            allow_q <= 1'b1;
            stall_q <= 1'b0;
        end else if (clk_en) begin
            ack_n_q <= (state_d != ARB_HOLD); // R4 R11
            want_n_q <= !((state_d == ARB_HOLD) && ext_access_req); // R8
            pull_q <= (state_d == ARB_HOLD); // R5
            if (arbitration_enable) begin
                armed_q <= 1'b1; // R10
            end
            allow_q <= (state_d == ARB_NORMAL); // R4
            stall_q <= ext_access_req && (state_d != ARB_NORMAL); // R7
        end
    end

    // ****************************************
    // Address, data and segment pins
    // ****************************************
    logic [DATA_W-1:0] ad_q, addr_q;
    logic [SEG_W-1:0] seg_q;
    logic ad_oe_q, addr_oe_q, seg_oe_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ad_q <= '0;
            ad_oe_q <= 1'b0;
            addr_oe_q <= 1'b0;
            seg_oe_q <= 1'b0;
        end else if (clk_en) begin
            ad_q <= cyc_ad_out;
            ad_oe_q <= bus_if_en && cyc_active && cyc_ad_oe && !float_d; // R1 R5
            addr_oe_q <= bus_if_en && addr_port_used && !float_d; // R1 R5
            seg_oe_q <= bus_if_en && !float_d; // R1 R5
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            addr_q <= '0;
            seg_q <= '0;
        end else if (clk_en && cyc_active) begin
            addr_q <= cyc_addr; // R1
            seg_q <= cyc_seg; // R1
        end
    end

    // ****************************************
    // Strobe pins
    // ****************************************
    logic ale_q, rd_n_q, wrl_n_q, bhe_n_q, ctl_oe_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ale_q <= `EBC_ALE_IDLE;
            rd_n_q <= `EBC_STROBE_IDLE;
            wrl_n_q <= `EBC_STROBE_IDLE;
            bhe_n_q <= `EBC_STROBE_IDLE;
            ctl_oe_q <= 1'b0;
        end else if (clk_en) begin
            if (cyc_active && !float_d) begin
                ale_q <= cyc_ale;
                rd_n_q <= cyc_rd_n;
                wrl_n_q <= cyc_write_low_byte_n;
                bhe_n_q <= cyc_byte_high_enable_n;
            end else begin
                ale_q <= `EBC_ALE_IDLE; // R2 R5
                rd_n_q <= `EBC_STROBE_IDLE; // R2 R5
                wrl_n_q <= `EBC_STROBE_IDLE; // R2 R5
                bhe_n_q <= `EBC_STROBE_IDLE; // R5
            end
            ctl_oe_q <= bus_if_en && !float_d; // R5 R11
        end
    end

    // ****************************************
    // Chip select pins
    // ****************************************
    logic [NUM_CS-1:0] cs_q, cs_oe_q;

    for (genvar i = 0; i < NUM_CS; i++) begin : g_cs
        always_ff @(posedge core_clk) begin
            if (rst) begin
                cs_q[i] <= 1'b1;
                cs_oe_q[i] <= 1'b0;
            end else if (clk_en) begin
                if (float_d) begin
                    cs_q[i] <= 1'b1; // R6
                    cs_oe_q[i] <= !cs_open_drain[i]; // R6
                end else begin
                    cs_q[i] <= cyc_cs_n[i]; // R2
                    cs_oe_q[i] <= bus_if_en && cs_enable
                        && (!cs_open_drain[i] || !cyc_cs_n[i]); // R2
                end
            end
        end
    end

    // ****************************************
    // Output connections
    // ****************************************
    assign muxed_addr_data_out = ad_q;
    assign muxed_addr_data_oe = ad_oe_q;
    assign intra_segment_addr_out = addr_q;
    assign intra_segment_addr_oe = addr_oe_q;
    assign seg_addr_out = seg_q;
    assign seg_addr_oe = seg_oe_q;
    assign ale_out = ale_q;
    assign ale_oe = ctl_oe_q;
    assign ale_pulldown_en = pull_q;
    assign rd_n_out = rd_n_q;
    assign write_low_byte_n = wrl_n_q;
    assign byte_high_enable_n = bhe_n_q;
    assign cmd_oe = ctl_oe_q;
    assign cmd_pullup_en = pull_q;
    assign cs_n_out = cs_q;
    assign cs_oe = cs_oe_q;
    assign bus_grant_ack_n = ack_n_q;
    assign bus_want_back_n = want_n_q;
    assign arb_pins_oe = armed_q;
    assign cycle_allow = allow_q;
    assign core_stall = stall_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk iff clk_en);
    endclocking
    default disable iff (rst);
    sequence s_release_seen;
        (state_q == ARB_HOLD) && hold_sync_q;
    endsequence
    sequence s_ack_then_drive;
        (bus_grant_ack_n && !cmd_oe) ##1 (cmd_oe || !bus_if_en);
    endsequence
    property p_idle_float;
        (bus_if_en && !cyc_active) |=> !muxed_addr_data_oe;
    endproperty
    a_idle_float: assert property (p_idle_float) // R1
        else $error("muxed port driven while idle");
    property p_addr_kept;
        !cyc_active |=> $stable(intra_segment_addr_out) && $stable(seg_addr_out);
    endproperty
    a_addr_kept: assert property (p_addr_kept) // R1
        else $error("address changed while idle");
    property p_idle_strobes;
        !cyc_active |=> !ale_out && rd_n_out && write_low_byte_n;
    endproperty
    a_idle_strobes: assert property (p_idle_strobes) // R2
        else $error("strobe active while idle");
    property p_grant;
        (state_q == ARB_DRAIN && !cyc_active && !hold_sync_q) |=> !bus_grant_ack_n;
    endproperty
    a_grant: assert property (p_grant) // R4
        else $error("grant not given after cycle end");
    property p_hold_float;
        !bus_grant_ack_n |-> !muxed_addr_data_oe && !intra_segment_addr_oe
            && !cmd_oe && ale_pulldown_en && cmd_pullup_en;
    endproperty
    a_hold_float: assert property (p_hold_float) // R5
        else $error("bus not released in hold");
    property p_hold_cs;
        !bus_grant_ack_n |-> (&cs_n_out) && (cs_oe == ~$past(cs_open_drain));
    endproperty
    a_hold_cs: assert property (p_hold_cs) // R6
        else $error("chip select wrong in hold");
    property p_want_only_hold;
        !bus_want_back_n |-> !bus_grant_ack_n && $past(ext_access_req);
    endproperty
    a_want_only_hold: assert property (p_want_only_hold) // R8
        else $error("bus request outside hold");
    property p_ignore;
        (state_q == ARB_NORMAL && !arbitration_enable) |=> state_q == ARB_NORMAL;
    endproperty
    a_ignore: assert property (p_ignore) // R9
        else $error("hold honoured while disabled");
    property p_armed;
        arb_pins_oe |=> arb_pins_oe;
    endproperty
    a_armed: assert property (p_armed) // R10
        else $error("arbitration pins lost function");
    property p_release;
        s_release_seen |=> s_ack_then_drive;
    endproperty
    a_release: assert property (p_release) // R11
        else $error("release order wrong");
    property p_sync;
        $fell(hold_sync_q) |-> $past(hold_req_n, 2) == 1'b0;
    endproperty
    a_sync: assert property (p_sync) // R15
        else $error("hold request not synchronised");
    property p_stall;
        core_stall |-> $past(ext_access_req) && !cycle_allow;
    endproperty
    a_stall: assert property (p_stall) // R7
        else $error("stall without external need");
endmodule : bus_hold_arbiter

// >>> tb/external_bus_hold_arbitration_bench.sv
// Purpose: Self-checking bench of the hold arbitration block
// Assumes: Bench plays the bus cycle engine and the core
// Notes: Inputs change at the falling edge, outputs read there
`timescale 1ns/10ps
module external_bus_hold_arbitration_bench import ebc_arb_pkg::*;;
    // ****
    // Stimulus and wiring
    // ****
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic want_bus = 1'b0;
    logic yield_on_want = 1'b0;
    logic arbitration_enable = 1'b0;
    logic ext_access_req = 1'b0;
    logic cyc_active = 1'b0;
    logic cyc_ale = 1'b0;
    logic cyc_rd_n = 1'b1;
    logic cyc_write_low_byte_n = 1'b1;
    logic cyc_byte_high_enable_n = 1'b1;
    logic cyc_ad_oe = 1'b0;
    logic cs_enable = 1'b1;
    logic addr_port_used = 1'b1;
    logic [4:0] bus_active_bit = 5'h00;
    logic [4:0] cyc_cs_n = 5'h1f;
    logic [4:0] cs_open_drain = 5'h18;
    logic [15:0] cyc_ad_out = 16'h0000;
    logic [15:0] cyc_addr = 16'h0000;
    logic [7:0] cyc_seg = 8'h00;
    logic [15:0] muxed_addr_data_out;
    logic [15:0] intra_segment_addr_out;
    logic [7:0] seg_addr_out;
    logic [4:0] cs_n_out;
    logic [4:0] cs_oe;
    logic muxed_addr_data_oe, intra_segment_addr_oe, seg_addr_oe, ale_out, ale_oe;
    logic ale_pulldown_en, rd_n_out, write_low_byte_n, byte_high_enable_n, cmd_oe;
    logic cmd_pullup_en, bus_grant_ack_n, bus_want_back_n, arb_pins_oe;
    logic cycle_allow, core_stall, hold_req_n;
    int error_cnt = 0;
    int samples_checked = 0;

    always #4 core_clk = ~core_clk;

    bus_hold_arbiter uut (
        .core_clk, .rst, .clk_en, .hold_req_n, .arbitration_enable, .bus_active_bit,
        .ext_access_req, .cyc_active, .cyc_ale, .cyc_rd_n, .cyc_write_low_byte_n,
        .cyc_byte_high_enable_n, .cyc_ad_out, .cyc_ad_oe, .cyc_addr, .cyc_seg,
        .cyc_cs_n, .cs_enable, .cs_open_drain, .addr_port_used, .muxed_addr_data_out,
        .muxed_addr_data_oe, .intra_segment_addr_out, .intra_segment_addr_oe,
        .seg_addr_out, .seg_addr_oe, .ale_out, .ale_oe, .ale_pulldown_en, .rd_n_out,
        .write_low_byte_n, .byte_high_enable_n, .cmd_oe, .cmd_pullup_en, .cs_n_out,
        .cs_oe, .bus_grant_ack_n, .bus_want_back_n, .arb_pins_oe, .cycle_allow,
        .core_stall
    );

    hold_master_model master (
        .core_clk, .want_bus, .yield_on_want, .bus_grant_ack_n, .bus_want_back_n,
        .hold_req_n
    );

    // ****
    // Helpers
    // ****
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    task automatic wait_ack(input logic v);
        int n;
        n = 0;
        while (bus_grant_ack_n !== v && n < 20) begin
            @(negedge core_clk);
            n++;
        end
    endtask : wait_ack

    task automatic wrap_up;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // ****
    // Scenarios
    // ****
    task automatic t_reset_idle;
        chk("ack_n", 1, bus_grant_ack_n);
        chk("want_n", 1, bus_want_back_n);
        chk("pins_oe", 0, arb_pins_oe);
        chk("addr_oe", 0, intra_segment_addr_oe);
    endtask : t_reset_idle

    task automatic t_idle_pins;
        bus_active_bit = 5'h04;
        cyc_active = 1'b1;
        cyc_ale = 1'b1;
        cyc_rd_n = 1'b0;
        cyc_ad_oe = 1'b1;
        cyc_ad_out = 16'h5a5a;
        cyc_addr = 16'h1234;
        cyc_seg = 8'h3c;
        cyc_cs_n = 5'h1e;
        cyc_write_low_byte_n = 1'b0;
        tick(2);
        chk("mux_oe", 1, muxed_addr_data_oe);
        chk("mux", 16'h5a5a, muxed_addr_data_out);
        chk("ale", 1, ale_out);
        chk("wrl_n", 0, write_low_byte_n);
        cyc_active = 1'b0;
        cyc_ale = 1'b0;
        cyc_rd_n = 1'b1;
        cyc_write_low_byte_n = 1'b1;
        cyc_ad_oe = 1'b0;
        cyc_addr = 16'hffff;
        tick(2);
        chk("mux_oe", 0, muxed_addr_data_oe);
        chk("addr", 16'h1234, intra_segment_addr_out);
        chk("addr_oe", 1, intra_segment_addr_oe);
        chk("seg", 8'h3c, seg_addr_out);
        chk("ale", 0, ale_out);
        chk("rd_n", 1, rd_n_out);
        chk("cs_n", 5'h1e, cs_n_out);
        chk("cs_oe0", 1, cs_oe[0]);
        chk("strobes_n", 2'b11, {write_low_byte_n, byte_high_enable_n});
        clk_en = 1'b0;
        cyc_active = 1'b1;
        cyc_ale = 1'b1;
        tick(2);
        chk("frozen_addr", 16'h1234, intra_segment_addr_out);
        chk("frozen_ale", 0, ale_out);
        clk_en = 1'b1;
        cyc_active = 1'b0;
        cyc_ale = 1'b0;
    endtask : t_idle_pins

    task automatic t_grant;
        arbitration_enable = 1'b1;
        tick(2);
        chk("pins_oe", 1, arb_pins_oe);
        cyc_active = 1'b1;
        want_bus = 1'b1;
        yield_on_want = 1'b1;
        tick(8);
        chk("ack_n", 1, bus_grant_ack_n);
        cyc_active = 1'b0;
        wait_ack(1'b0);
        chk("ack_n", 0, bus_grant_ack_n);
        chk("mux_oe", 0, muxed_addr_data_oe);
        chk("addr_oe", 0, intra_segment_addr_oe);
        chk("seg_oe", 0, seg_addr_oe);
        chk("cmd_oe", 0, cmd_oe);
        chk("pulls", 2'b11, {ale_pulldown_en, cmd_pullup_en});
        chk("cs_n", 5'h07, cs_n_out & 5'h07);
        chk("cs_oe", 5'h07, cs_oe);
        chk("want_n", 1, bus_want_back_n);
        chk("stall", 0, core_stall);
        ext_access_req = 1'b1;
        tick(1);
        chk("want_n", 0, bus_want_back_n);
        chk("stall", 1, core_stall);
        wait_ack(1'b1);
        chk("ack_n", 1, bus_grant_ack_n);
        chk("cmd_oe", 0, cmd_oe);
        tick(1);
        chk("oe", 2'b11, {cmd_oe, ale_oe});
        chk("allow", 1, cycle_allow);
        chk("stall", 0, core_stall);
        chk("want_n", 1, bus_want_back_n);
        ext_access_req = 1'b0;
        want_bus = 1'b0;
        yield_on_want = 1'b0;
        arbitration_enable = 1'b0;
        tick(3);
        chk("pins_oe", 1, arb_pins_oe);
    endtask : t_grant

    task automatic t_refused;
        want_bus = 1'b1;
        tick(10);
        chk("ack_n", 1, bus_grant_ack_n);
        chk("allow", 1, cycle_allow);
        want_bus = 1'b0;
        tick(4);
    endtask : t_refused

    task automatic t_abort_drain;
        arbitration_enable = 1'b1;
        cyc_active = 1'b1;
        want_bus = 1'b1;
        tick(5);
        chk("allow", 0, cycle_allow);
        want_bus = 1'b0;
        tick(4);
        chk("allow", 1, cycle_allow);
        cyc_active = 1'b0;
        repeat (6) begin
            tick(1);
            chk("ack_n", 1, bus_grant_ack_n);
        end
    endtask : t_abort_drain

    // ****
    // Main sequence and watchdog
    // ****
    initial begin
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        tick(1);
        t_reset_idle();
        t_idle_pins();
        t_grant();
        t_refused();
        t_abort_drain();
        wrap_up();
    end

    // Tests need about 80 cycles; allow over ten times that
    initial begin
        #20000;
        error_cnt++;
        wrap_up();
    end
endmodule : external_bus_hold_arbitration_bench

// >>> tb/hold_master_model.sv
// Purpose: Other bus master behind the arbitration circuit
// Assumes: Changes its pin just after the rising edge of core_clk
// Notes: Optionally yields as soon as the device wants its bus back
`timescale 1ns/10ps
module hold_master_model (
    input wire logic core_clk,
    input wire logic want_bus,
    input wire logic yield_on_want,
    input wire logic bus_grant_ack_n,
    input wire logic bus_want_back_n,
    output logic hold_req_n
);
    // ****
    // Hold request driver
    // ****
    logic yielded_q = 1'b0;

    initial hold_req_n = 1'b1;

    always @(posedge core_clk) begin
        if (!want_bus) begin
            hold_req_n <= 1'b1;
            yielded_q <= 1'b0;
        end else if (yielded_q || (yield_on_want && bus_want_back_n === 1'b0
                     && bus_grant_ack_n === 1'b0)) begin
            hold_req_n <= 1'b1;
            yielded_q <= 1'b1;
        end else begin
            hold_req_n <= 1'b0;
        end
    end
endmodule : hold_master_model
